//--- rtl/xbr_pkg.sv
package xbr_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NM = 5; // Masters
    localparam int NT = 5; // Target groups
    localparam int NS = 4; // Sources arbitrated on system clock two
    localparam int DW = 32; // Data and address width
    localparam int MIDW = 3; // Master id width
    localparam int BR_DEPTH = 4; // Bridge FIFO depth
    // ------------------------------------------------------------
    // Master indices
    // ------------------------------------------------------------
    localparam int M_DATA = 0; // data_memory_master
    localparam int M_FILL = 1; // program_fill_master
    localparam int M_HIDMA = 2; // high_priority_dma_master
    localparam int M_LODMA = 3; // low_priority_dma_master
    localparam int M_HOST = 4; // host_port_master
    // ------------------------------------------------------------
    // Target indices
    // ------------------------------------------------------------
    localparam int T_ONCHIP = 0; // On-chip memory via cpu_slave_port
    localparam int T_EXTMEM = 1; // external_memory_target
    localparam int T_PERCFG = 2; // Peripheral configuration bus
    localparam int T_AUDIO = 3; // audio_serializer_target DMA bus
    localparam int T_DMAREG = 4; // dma_accelerator registers
    // ------------------------------------------------------------
    // Address decode on the top nibble
    // ------------------------------------------------------------
    localparam logic [3:0] NIB_ROM = 4'h0;
    localparam logic [3:0] NIB_RAM = 4'h1;
    localparam logic [3:0] NIB_AUDIO = 4'h5;
    localparam logic [3:0] NIB_DMAREG = 4'h6;
    localparam logic [3:0] NIB_SDRAM = 4'h8;
    localparam logic [3:0] NIB_ASYNC = 4'h9;
    // ------------------------------------------------------------
    // bridge_reset_control register
    // ------------------------------------------------------------
    localparam logic [31:0] BRIDGE_CTRL_ADDR = 32'h4000_0024;
    localparam int SPB_RST_BIT = 0; // slave_port_bridge_reset
    localparam logic SPB_RST_RESET = 1'h1;
    localparam logic [30:0] CTRL_RSVD_READ = 31'h0;
    // ------------------------------------------------------------
    // Packet layout carried through bridges
    // ------------------------------------------------------------
    localparam int P_WDATA = 0;
    localparam int P_ADDR = 32;
    localparam int P_WE = 64;
    localparam int P_LAST = 65;
    localparam int P_MID = 66;
    localparam int PKT_W = 69;
    // System clock divider indices
    localparam int EN_ONE = 0;
    localparam int EN_TWO = 1;
    localparam int EN_THREE = 2;

    // Target group of an address
    function automatic logic [2:0] decode_target(input logic [31:0] addr);
        logic [3:0] nib;
        nib = addr[31:28];
        if (nib == NIB_ROM || nib == NIB_RAM) begin
            return 3'(T_ONCHIP);
        end else if (nib == NIB_SDRAM || nib == NIB_ASYNC) begin
            return 3'(T_EXTMEM);
        end else if (nib == NIB_AUDIO) begin
            return 3'(T_AUDIO);
        end else if (nib == NIB_DMAREG) begin
            return 3'(T_DMAREG);
        end else begin
            return 3'(T_PERCFG);
        end
    endfunction : decode_target

    // Pack one beat
    function automatic logic [PKT_W-1:0] pack(input logic [31:0] addr,
        input logic we, input logic [31:0] wdata, input logic last,
        input logic [2:0] mid);
        return {mid, last, we, addr, wdata};
    endfunction : pack
endpackage : xbr_pkg

//--- rtl/xbr_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module xbr_bridge #(
    parameter int W = 8,
    parameter int DEPTH = 4,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_flush,
    input wire logic i_in_en,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    input wire logic i_out_en,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [W-1:0] mem [DEPTH]; // FIFO entries
    logic [AW:0] wr_ptr; // Write pointer with wrap bit
    logic [AW:0] rd_ptr; // Read pointer with wrap bit
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (wr_ptr[AW] != rd_ptr[AW])
        && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    // Accept only on the master-side edge, never while flushing
    assign o_in_ready = i_in_en && !full && !i_flush;
    assign o_out_valid = !empty && !i_flush;
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_en && i_out_ready && o_out_valid;
    assign o_out_data = mem[rd_ptr[AW-1:0]];

    // Pointer update, flush empties the FIFO
    always_ff @(posedge i_clk) begin
        if (i_reset || i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Entry write
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_fifo_no_overrun:
        assert property (full |-> !push)
        else $error("bridge pushed while full");
    a_in_rate:
        assert property (push |=> (wr_ptr != rd_ptr) || $past(pop)
            || $past(i_flush))
        else $error("bridge push lost an entry");
    a_flush_empty:
        assert property (i_flush |=> empty && !o_out_valid)
        else $error("bridge not empty after flush");
endmodule : xbr_bridge
`default_nettype wire

//--- rtl/xbr_crossbar.sv
// Summary of operation
// - Accept requests from five bus masters
// - Route requests to five target groups
// - Independent paths run concurrently without stalls
// - Same-cycle contention: highest priority wins, others stall
// - Owner finishes whole access before re-arbitration
// - High-priority DMA beats low-priority DMA
// - Fill requests cross one bridge, lowest priority
// - Bridge FIFO accepts at master, sends at target
// - Bridge one: CPU data, clock one to two
// - Bridge two: DMA/host to on-chip, two to one
// - External memory bridges issue on clock three
// - Control bit0 holds slave bridge reset, resets 1
// - Control bits 31:1 reserved, write zeros
`timescale 1ns/1ps
`default_nettype none
module xbr_crossbar #(
    parameter int unsigned DIV_ONE = 1,
    parameter int unsigned DIV_TWO = 2,
    parameter int unsigned DIV_THREE = 4,
    parameter int BR_DEPTH = xbr_pkg::BR_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [xbr_pkg::NM-1:0] i_m_req,
    input wire logic [31:0] i_m_addr [xbr_pkg::NM],
    input wire logic [xbr_pkg::NM-1:0] i_m_we,
    input wire logic [31:0] i_m_wdata [xbr_pkg::NM],
    input wire logic [xbr_pkg::NM-1:0] i_m_last,
    output logic [xbr_pkg::NM-1:0] o_m_ready,
    output logic [xbr_pkg::NM-1:0] o_m_rvalid,
    output logic [31:0] o_m_rdata [xbr_pkg::NM],
    output logic [xbr_pkg::NT-1:0] o_t_valid,
    output logic [31:0] o_t_addr [xbr_pkg::NT],
    output logic [xbr_pkg::NT-1:0] o_t_we,
    output logic [31:0] o_t_wdata [xbr_pkg::NT],
    output logic [xbr_pkg::NT-1:0] o_t_last,
    output logic [2:0] o_t_mid [xbr_pkg::NT],
    input wire logic [xbr_pkg::NT-1:0] i_t_ready,
    input wire logic [xbr_pkg::NT-1:0] i_t_rvalid,
    input wire logic [31:0] i_t_rdata [xbr_pkg::NT],
    output logic o_slave_port_bridge_reset
);
    localparam int NT = xbr_pkg::NT;
    localparam int NS = xbr_pkg::NS;
    localparam int PW = xbr_pkg::PKT_W;
    localparam int unsigned DIVS [3] = '{DIV_ONE, DIV_TWO, DIV_THREE};

    // ------------------------------------------------------------
    // System clock enables
    // ------------------------------------------------------------
    logic [2:0] sys_en; // One-cycle pulses per system clock
    logic [7:0] div_cnt [3]; // Divider counters

    for (genvar g = 0; g < 3; g++) begin : g_div
        // Divider count
        always_ff @(posedge i_clk) begin
            if (i_reset || div_cnt[g] == 8'(DIVS[g] - 1)) begin
                div_cnt[g] <= 8'h00;
            end else begin
                div_cnt[g] <= div_cnt[g] + 8'h01;
            end
        end
        assign sys_en[g] = (div_cnt[g] == 8'h00);
    end

    // ------------------------------------------------------------
    // Master packets and clock-one bridges
    // ------------------------------------------------------------
    logic [PW-1:0] m_pkt [xbr_pkg::NM]; // Packed master beats
    logic bridge_rst; // slave_port_bridge_reset bit
    logic br1_valid, br3_valid, br4_in_ready, br4_valid;
    logic br2_in_ready, br2_valid, br3_ready, br4_ready;
    logic [PW-1:0] br1_data, br2_data, br3_data, br4_data;
    logic [PW-1:0] src_pkt [NS]; // Clock-two sources
    logic [NS-1:0] src_valid;
    logic [NS-1:0] src_ready;
    logic [2:0] src_tgt [NS];

    for (genvar m = 0; m < xbr_pkg::NM; m++) begin : g_mpkt
        assign m_pkt[m] = xbr_pkg::pack(i_m_addr[m], i_m_we[m],
            i_m_wdata[m], i_m_last[m], 3'(m));
    end

    // CPU data crosses from clock one to clock two
    xbr_bridge #(.W(PW), .DEPTH(BR_DEPTH)) u_cpu_data_bridge (
        .i_clk(i_clk), .i_reset(i_reset), .i_flush(1'b0),
        .i_in_en(sys_en[xbr_pkg::EN_ONE]),
        .i_in_valid(i_m_req[xbr_pkg::M_DATA]),
        .o_in_ready(o_m_ready[xbr_pkg::M_DATA]),
        .i_in_data(m_pkt[xbr_pkg::M_DATA]),
        .i_out_en(sys_en[xbr_pkg::EN_TWO]), .o_out_valid(br1_valid),
        .i_out_ready(src_ready[0]), .o_out_data(br1_data));

    // Fill goes straight to external memory, one crossing only
    xbr_bridge #(.W(PW), .DEPTH(BR_DEPTH)) u_program_fill_bridge (
        .i_clk(i_clk), .i_reset(i_reset), .i_flush(1'b0),
        .i_in_en(sys_en[xbr_pkg::EN_ONE]),
        .i_in_valid(i_m_req[xbr_pkg::M_FILL]),
        .o_in_ready(o_m_ready[xbr_pkg::M_FILL]),
        .i_in_data(m_pkt[xbr_pkg::M_FILL]),
        .i_out_en(sys_en[xbr_pkg::EN_THREE]), .o_out_valid(br3_valid),
        .i_out_ready(br3_ready), .o_out_data(br3_data));

    // Source 0 is bridged CPU data, 1..3 the DMA and host masters
    assign src_pkt[0] = br1_data;
    assign src_valid[0] = br1_valid;
    for (genvar s = 1; s < NS; s++) begin : g_src
        assign src_pkt[s] = m_pkt[s + 1];
        assign src_valid[s] = i_m_req[s + 1];
        assign o_m_ready[s + 1] = src_ready[s];
    end
    for (genvar s = 0; s < NS; s++) begin : g_dec
        assign src_tgt[s] =
            xbr_pkg::decode_target(src_pkt[s][xbr_pkg::P_ADDR +: 32]);
    end

    // ------------------------------------------------------------
    // Per-target arbiters on clock two
    // ------------------------------------------------------------
    logic [NS-1:0] arb_req [NT]; // Requesters per target
    logic [1:0] arb_pick [NT]; // Fixed-priority choice
    logic [1:0] arb_sel [NT]; // Effective owner
    logic [1:0] arb_owner [NT]; // Locked owner
    logic arb_busy [NT]; // Access in progress
    logic arb_go [NT]; // Beat moves this cycle
    logic dest_ready [NT];
    logic [PW-1:0] arb_pkt [NT];
    logic reg_hit; // Beat addresses bridge_reset_control
    logic stage_free [NT];

    for (genvar t = 0; t < NT; t++) begin : g_arb
        for (genvar s = 0; s < NS; s++) begin : g_req
            assign arb_req[t][s] = src_valid[s] && src_tgt[s] == 3'(t);
        end
        // Lower source index wins
        assign arb_pick[t] = arb_req[t][0] ? 2'h0 :
            arb_req[t][1] ? 2'h1 :
            arb_req[t][2] ? 2'h2 : 2'h3;
        assign arb_sel[t] = arb_busy[t] ? arb_owner[t] : arb_pick[t];
        assign arb_pkt[t] = src_pkt[arb_sel[t]];
        // Each target moves on its own, no cross-target stall
        assign arb_go[t] = sys_en[xbr_pkg::EN_TWO]
            && arb_req[t][arb_sel[t]] && dest_ready[t];

        // Ownership held until the last beat
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                arb_busy[t] <= 1'b0;
                arb_owner[t] <= 2'h0;
            end else if (arb_go[t]) begin
                arb_busy[t] <= !arb_pkt[t][xbr_pkg::P_LAST];
                arb_owner[t] <= arb_sel[t];
            end
        end
    end

    // Ready back to whichever source moved
    always_comb begin
        src_ready = '0;
        for (int t = 0; t < NT; t++) begin
            if (arb_go[t]) begin
                src_ready[arb_sel[t]] = 1'b1;
            end
        end
    end

    assign reg_hit = (arb_pkt[xbr_pkg::T_PERCFG][xbr_pkg::P_ADDR +: 32]
        == xbr_pkg::BRIDGE_CTRL_ADDR);
    assign dest_ready[xbr_pkg::T_ONCHIP] = br2_in_ready;
    assign dest_ready[xbr_pkg::T_EXTMEM] = br4_in_ready;
    assign dest_ready[xbr_pkg::T_PERCFG] =
        reg_hit || stage_free[xbr_pkg::T_PERCFG];
    assign dest_ready[xbr_pkg::T_AUDIO] = stage_free[xbr_pkg::T_AUDIO];
    assign dest_ready[xbr_pkg::T_DMAREG] = stage_free[xbr_pkg::T_DMAREG];

    // DMA and host into on-chip memory, flushed by the control bit
    xbr_bridge #(.W(PW), .DEPTH(BR_DEPTH)) u_slave_port_bridge (
        .i_clk(i_clk), .i_reset(i_reset), .i_flush(bridge_rst),
        .i_in_en(sys_en[xbr_pkg::EN_TWO]),
        .i_in_valid(arb_go[xbr_pkg::T_ONCHIP]), .o_in_ready(br2_in_ready),
        .i_in_data(arb_pkt[xbr_pkg::T_ONCHIP]),
        .i_out_en(sys_en[xbr_pkg::EN_ONE]), .o_out_valid(br2_valid),
        .i_out_ready(stage_free[xbr_pkg::T_ONCHIP]),
        .o_out_data(br2_data));

    // CPU, host and DMA toward external memory on clock three
    xbr_bridge #(.W(PW), .DEPTH(BR_DEPTH)) u_shared_extmem_bridge (
        .i_clk(i_clk), .i_reset(i_reset), .i_flush(1'b0),
        .i_in_en(sys_en[xbr_pkg::EN_TWO]),
        .i_in_valid(arb_go[xbr_pkg::T_EXTMEM]), .o_in_ready(br4_in_ready),
        .i_in_data(arb_pkt[xbr_pkg::T_EXTMEM]),
        .i_out_en(sys_en[xbr_pkg::EN_THREE]), .o_out_valid(br4_valid),
        .i_out_ready(br4_ready), .o_out_data(br4_data));

    // ------------------------------------------------------------
    // External memory final arbiter, fill last
    // ------------------------------------------------------------
    logic ext_busy, ext_own, ext_sel, ext_valid, ext_go;

    assign ext_sel = ext_busy ? ext_own : !br4_valid;
    assign ext_valid = ext_sel ? br3_valid : br4_valid;
    assign ext_go = sys_en[xbr_pkg::EN_THREE] && ext_valid
        && stage_free[xbr_pkg::T_EXTMEM];
    assign br4_ready = ext_go && !ext_sel;
    assign br3_ready = ext_go && ext_sel;

    // Lock the external memory owner for the access
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ext_busy <= 1'b0;
            ext_own <= 1'b0;
        end else if (ext_go) begin
            ext_busy <= !o_t_last_next();
            ext_own <= ext_sel;
        end
    end

    function automatic logic o_t_last_next();
        return ext_sel ? br3_data[xbr_pkg::P_LAST]
            : br4_data[xbr_pkg::P_LAST];
    endfunction : o_t_last_next

    // ------------------------------------------------------------
    // Registered target output stages
    // ------------------------------------------------------------
    logic stg_take [NT]; // Load the stage
    logic stg_en [NT]; // Target clock enable
    logic [PW-1:0] stg_in [NT];
    logic stg_valid [NT];
    logic [PW-1:0] stg_pkt [NT];
    logic [2:0] resp_mid [NT]; // Master owed the next answer

    assign stg_en[0] = sys_en[xbr_pkg::EN_ONE];
    assign stg_en[1] = sys_en[xbr_pkg::EN_THREE];
    assign stg_take[0] = sys_en[xbr_pkg::EN_ONE] && br2_valid
        && stage_free[0];
    assign stg_take[1] = ext_go;
    assign stg_in[0] = br2_data;
    assign stg_in[1] = ext_sel ? br3_data : br4_data;
    for (genvar t = 2; t < NT; t++) begin : g_cfg
        assign stg_en[t] = sys_en[xbr_pkg::EN_TWO];
        assign stg_take[t] = arb_go[t]
            && !(t == xbr_pkg::T_PERCFG && reg_hit);
        assign stg_in[t] = arb_pkt[t];
    end

    for (genvar t = 0; t < NT; t++) begin : g_stage
        assign stage_free[t] = !stg_valid[t] || (stg_en[t] && i_t_ready[t]);
        // Hold a beat until the target takes it
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                stg_valid[t] <= 1'b0;
                stg_pkt[t] <= '0;
                resp_mid[t] <= 3'h0;
            end else begin
                if (stg_take[t]) begin
                    stg_valid[t] <= 1'b1;
                    stg_pkt[t] <= stg_in[t];
                end else if (stg_en[t] && i_t_ready[t]) begin
                    stg_valid[t] <= 1'b0;
                end
                if (stg_valid[t] && stg_en[t] && i_t_ready[t]) begin
                    resp_mid[t] <= stg_pkt[t][xbr_pkg::P_MID +: 3];
                end
            end
        end
        assign o_t_valid[t] = stg_valid[t];
        assign o_t_addr[t] = stg_pkt[t][xbr_pkg::P_ADDR +: 32];
        assign o_t_we[t] = stg_pkt[t][xbr_pkg::P_WE];
        assign o_t_wdata[t] = stg_pkt[t][xbr_pkg::P_WDATA +: 32];
        assign o_t_last[t] = stg_pkt[t][xbr_pkg::P_LAST];
        assign o_t_mid[t] = stg_pkt[t][xbr_pkg::P_MID +: 3];
    end

    // ------------------------------------------------------------
    // bridge_reset_control and read answers
    // ------------------------------------------------------------
    logic reg_write, reg_read;
    logic [2:0] reg_mid;

    assign reg_write = arb_go[xbr_pkg::T_PERCFG] && reg_hit
        && arb_pkt[xbr_pkg::T_PERCFG][xbr_pkg::P_WE];
    assign reg_read = arb_go[xbr_pkg::T_PERCFG] && reg_hit
        && !arb_pkt[xbr_pkg::T_PERCFG][xbr_pkg::P_WE];
    assign reg_mid = arb_pkt[xbr_pkg::T_PERCFG][xbr_pkg::P_MID +: 3];
    assign o_slave_port_bridge_reset = bridge_rst;

    // Control bit, reserved bits dropped on write
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            bridge_rst <= xbr_pkg::SPB_RST_RESET;
        end else if (reg_write) begin
            bridge_rst <=
                arb_pkt[xbr_pkg::T_PERCFG][xbr_pkg::SPB_RST_BIT];
        end
    end

    // Route answers to the master that owns them
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_m_rvalid <= '0;
            o_m_rdata <= '{default: 32'h0};
        end else begin
            o_m_rvalid <= '0;
            for (int t = NT - 1; t >= 0; t--) begin
                if (i_t_rvalid[t]) begin
                    o_m_rvalid[resp_mid[t]] <= 1'b1;
                    o_m_rdata[resp_mid[t]] <= i_t_rdata[t];
                end
            end
            if (reg_read) begin
                o_m_rvalid[reg_mid] <= 1'b1;
                o_m_rdata[reg_mid] <=
                    {xbr_pkg::CTRL_RSVD_READ, bridge_rst};
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [2:0] rd_mid_q; // Helper: reg_mid from the previous cycle, taken every cycle
    always_ff @(posedge i_clk) begin
        rd_mid_q <= reg_mid;
    end

    for (genvar t = 0; t < NT; t++) begin : g_chk
        sequence s_burst_open;
            arb_go[t] ##0 !arb_pkt[t][xbr_pkg::P_LAST];
        endsequence
        a_burst_lock:
            assert property (s_burst_open |=> arb_busy[t]
                && arb_owner[t] == $past(arb_sel[t]))
            else $error("owner changed inside an access");
        a_hi_dma_wins:
            assert property (!arb_busy[t] && arb_go[t] && !arb_req[t][0]
                && arb_req[t][1] && arb_req[t][2]
                |-> src_ready[1] && !src_ready[2])
            else $error("low DMA beat high DMA");
        a_no_stall:
            assert property (sys_en[xbr_pkg::EN_TWO] && !arb_busy[t]
                && (|arb_req[t]) && dest_ready[t] |-> arb_go[t])
            else $error("free path stalled");
        for (genvar s = 0; s < NS; s++) begin : g_prio
            a_fixed_prio:
                assert property (!arb_busy[t] && arb_go[t] && arb_req[t][s]
                    |-> arb_sel[t] <= 2'(s))
                else $error("lower priority granted");
        end
    end
    a_fill_last:
        assert property (!ext_busy && br4_valid |-> !ext_sel)
        else $error("fill beat shared bridge to external memory");
    a_ctrl_reset:
        assert property (@(posedge i_clk) disable iff (1'b0)
            i_reset |=> bridge_rst)
        else $error("control bit not 1 after reset");
    a_ctrl_write:
        assert property (reg_write |=> bridge_rst
            == $past(arb_pkt[xbr_pkg::T_PERCFG][xbr_pkg::SPB_RST_BIT]))
        else $error("control write not stored");
    a_rsvd_zero:
        assert property (reg_read |=> o_m_rvalid[rd_mid_q]
            && o_m_rdata[rd_mid_q][31:1] == 31'h0)
        else $error("control read answer wrong");
    a_slave_hold:
        assert property (bridge_rst |-> !dest_ready[xbr_pkg::T_ONCHIP]
            && !arb_go[xbr_pkg::T_ONCHIP])
        else $error("on-chip beat taken during bridge reset");
endmodule : xbr_crossbar
`default_nettype wire

//--- testbench/xbr_tgt_model.sv
`timescale 1ns/1ps
`default_nettype none
module xbr_tgt_model #(
    parameter logic [4:0] SLOW = 5'h04
) (
    input wire logic i_clk,
    input wire logic i_reset,
    output logic [4:0] o_ready,
    output logic [4:0] o_rvalid,
    output logic [31:0] o_rdata [5]
);
    // Slow targets take a beat only every other cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_ready <= 5'h1f;
        end else begin
            o_ready <= o_ready ^ SLOW;
        end
    end
    // No read answers; data lines never hold a steady value out of reset
    always_ff @(posedge i_clk) begin
        o_rvalid <= 5'h00;
        for (int i = 0; i < 5; i++) begin
            o_rdata[i] <= i_reset ? 32'h5a5a_5a5a : ~o_rdata[i];
        end
    end
endmodule : xbr_tgt_model
`default_nettype wire

//--- testbench/xbr_crossbar_tb.sv
`timescale 1ns/1ps
`default_nettype none
module xbr_crossbar_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [4:0] req = '0, we = '0, last = '1, rdy, taken, rv, tv, twe, tl;
    logic [4:0] t_rdy, t_rv;
    logic [31:0] addr [5] = '{default: 32'h0}, wd [5] = '{default: 32'h0};
    logic [31:0] rd [5], ta [5], twd [5], trd [5];
    logic [2:0] tmid [5];
    logic spb_rst;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    always #50 i_clk = ~i_clk;
    // Registered handshake: ready while requesting
    always @(posedge i_clk) taken <= rdy & req;
    xbr_crossbar u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_m_req(req),
        .i_m_addr(addr), .i_m_we(we), .i_m_wdata(wd), .i_m_last(last),
        .o_m_ready(rdy), .o_m_rvalid(rv), .o_m_rdata(rd), .o_t_valid(tv),
        .o_t_addr(ta), .o_t_we(twe), .o_t_wdata(twd), .o_t_last(tl),
        .o_t_mid(tmid), .i_t_ready(t_rdy), .i_t_rvalid(t_rv),
        .i_t_rdata(trd), .o_slave_port_bridge_reset(spb_rst));
    xbr_tgt_model u_tgt (.i_clk(i_clk), .i_reset(i_reset), .o_ready(t_rdy),
        .o_rvalid(t_rv), .o_rdata(trd));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : check
    // One beat, held until taken
    task automatic beat(input int m, input logic [31:0] a, input logic w);
        @(posedge i_clk) #1;
        addr[m] = a;
        we[m] = w;
        wd[m] = {a[15:0], a[31:16]};
        req[m] = 1'b1;
        for (int k = 0; k < 60 && taken[m] !== 1'b1; k++) @(posedge i_clk) #1;
        req[m] = 1'b0;
        check("taken", 32'h1, {31'h0, taken[m]});
    endtask : beat
    // Wait for a target beat and compare its master id
    task automatic expect_t(input int t, input logic [2:0] mid);
        for (int k = 0; k < 60 && tv[t] !== 1'b1; k++) @(posedge i_clk) #1;
        check("t_mid", {28'h0, 1'b1, mid}, {28'h0, tv[t], tmid[t]});
        check("t_addr", addr[mid], ta[t]);
        check("t_wd", wd[mid], twd[t]);
        check("t_we", {30'h0, we[mid], last[mid]},
            {30'h0, twe[t], tl[t]});
        // Let the beat drain so the next wait sees a fresh one
        for (int k = 0; k < 60 && tv[t] === 1'b1; k++) @(posedge i_clk) #1;
    endtask : expect_t
    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // Cycle ceiling against hangs
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_stall;
        logic seen = 1'b0;
        check("bit0", 32'h1, {31'h0, spb_rst});
        addr[4] = 32'h1000_0000;
        req[4] = 1'b1;
        repeat (20) begin
            @(posedge i_clk) #1;
            seen |= taken[4];
        end
        req[4] = 1'b0;
        check("stall", 32'h0, {31'h0, seen});
    endtask : t_stall
    task automatic t_ctrl;
        // Read the reset value, clear the bit, read it again
        for (int v = 1; v >= 0; v--) begin
            if (v == 0) beat(2, 32'h4000_0024, 1'b1);
            beat(2, 32'h4000_0024, 1'b0);
            check("rv", 32'h1, {31'h0, rv[2]});
            check("rd", v, rd[2]);
            check("bit0", v, {31'h0, spb_rst});
        end
        beat(4, 32'h1000_0000, 1'b1);
        expect_t(0, 3'h4);
    endtask : t_ctrl
    task automatic t_prio;
        logic [2:0] first = 3'h7;
        // Two DMA ports to two different targets move together
        addr[2] = 32'h5400_0000;
        addr[3] = 32'h6000_0000;
        req[3:2] = 2'b11;
        for (int k = 0; k < 10 && taken[3:2] == 0; k++) @(posedge i_clk) #1;
        check("par", 32'h3, {30'h0, taken[3:2]});
        req[3:2] = 2'b00;
        @(posedge i_clk) #1;
        addr[2] = 32'h4200_0000;
        addr[3] = 32'h4700_0000;
        req[3:2] = 2'b11;
        repeat (60) begin
            @(posedge i_clk) #1;
            req = req & ~taken;
            if (tv[2] === 1'b1 && first == 3'h7) first = tmid[2];
        end
        check("winner", 32'h2, {29'h0, first});
        check("req", 32'h0, {27'h0, req});
    endtask : t_prio
    initial begin
        repeat (16) @(posedge i_clk);
        #1 i_reset = 1'b0;
        t_stall();
        t_ctrl();
        t_prio();
        beat(4, 32'h5400_0000, 1'b1);
        expect_t(3, 3'h4);
        beat(0, 32'h8000_0000, 1'b1);
        expect_t(1, 3'h0);
        beat(1, 32'h9000_0000, 1'b0);
        expect_t(1, 3'h1);
        close_out();
    end
endmodule : xbr_crossbar_tb
`default_nettype wire
